// file: logic/emp_mapper.v
// emp_mapper.v: expanded-memory page mapper, i/o-programmed page registers
// translating two memory windows into physical page numbers.
// assumes host i/o strobes and memory requests come from logic on CLOCK.
`default_nettype none
`include "emp_map.vh"

module emp_mapper #(
    parameter [3:0] PORT_X = 4'h8
) (
    input  wire        CLOCK,
    input  wire        RESET_N,
    input  wire [15:0] IO_ADDR,
    input  wire        IO_WR,
    input  wire        IO_RD,
    input  wire [7:0]  IO_WDATA,
    output wire        IO_HIT,
    output wire [7:0]  IO_RDATA,
    output wire        IO_RVALID,
    input  wire        MEM_REQ,
    input  wire [23:0] MEM_ADDR,
    input  wire [31:0] LOW_FRAME_TAG,
    input  wire [11:0] UPPER_FRAME_TAG,
    output wire        MAP_DONE,
    output wire        MAP_HIT,
    output wire [10:0] MAP_PAGE,
    output wire        MAP_WAIT,
    output wire        PORTS_ON,
    output wire        ACTIVE_SET
);

    // byte of a mapping word picked by the byte pointer or by the upper map port address
    function [7:0] emp_byte_pick;
        input [15:0] word;
        input        hi;
        begin
            emp_byte_pick = hi ? word[15:8] : word[7:0];
        end
    endfunction

    // physical page number from a mapping word
    function [10:0] emp_page;
        input [15:0] word;
        begin
            emp_page = {word[10:8], 1'b0, word[6:0]};
        end
    endfunction

    reg  [7:0]  frame_base_ff;
    reg  [7:0]  nxt_frame_base;
    reg  [6:0]  pointer_ff;
    reg  [6:0]  nxt_pointer;
    reg  [15:0] upper_map_ff [0:7];
    reg  [7:0]  io_rdata_ff;
    reg  [7:0]  nxt_io_rdata;
    reg         io_rvalid_ff;
    reg         rd_from_ram_ff;
    reg         rd_byte_ff;
    reg         s1_valid_ff;
    reg         s1_low_ff;
    reg         s1_up_ff;
    reg  [15:0] s1_up_word_ff;
    reg         map_done_ff;
    reg         map_hit_ff;
    reg  [10:0] map_page_ff;
    reg         map_wait_ff;
    integer     k;

    wire        mid_ok;
    wire        sel_frame_base;
    wire        sel_pointer;
    wire        sel_window;
    wire        sel_map;
    wire        ports_en;
    wire [2:0]  map_num;
    wire        win_wr;
    wire        win_rd;
    wire [15:0] ram_rd_a;
    wire [15:0] ram_rd_b;
    wire [5:0]  frame;
    wire        below_1mb;
    wire        in_low;
    wire        in_up;
    wire [5:0]  low_off;
    wire [3:0]  up_off;
    wire [3:0]  up_diff;
    wire        up_slot_ok;
    wire [2:0]  up_num;
    wire [5:0]  ram_b_addr;
    wire [15:0] s1_word;
    wire        s1_enabled;

    // i/o decode
    assign mid_ok         = (IO_ADDR[11:8] == `EMP_PORT_MID_NIB) && (IO_ADDR[7:4] == PORT_X);
    assign ports_en       = frame_base_ff[`EMP_FB_PORT_EN_BIT];
    // frame base port stays reachable so the ports can be turned back on
    assign sel_frame_base = mid_ok && (IO_ADDR[15:12] == `EMP_HI_FRAME_BASE)
                            && (IO_ADDR[3:0] == `EMP_LO_FRAME_BASE);
    assign sel_pointer    = mid_ok && ports_en && (IO_ADDR[15:12] == `EMP_HI_POINTER)
                            && (IO_ADDR[3:0] == `EMP_LO_POINTER);
    assign sel_window     = mid_ok && ports_en && (IO_ADDR[15:12] == `EMP_HI_WINDOW)
                            && (IO_ADDR[3:0] == `EMP_LO_WINDOW);
    assign sel_map        = mid_ok && ports_en && !IO_ADDR[`EMP_MAP_ZERO_BIT]
                            && ((IO_ADDR[3:0] == `EMP_LO_MAP_LOW)
                            || (IO_ADDR[3:0] == `EMP_LO_MAP_HIGH));
    assign map_num        = {IO_ADDR[`EMP_MAP_SET_BIT], IO_ADDR[15:`EMP_MAP_SLOT_LSB]};
    assign win_wr         = sel_window && IO_WR;
    assign win_rd         = sel_window && IO_RD;
    assign IO_HIT         = sel_frame_base || sel_pointer || sel_window || sel_map;

    // register writes and pointer byte flip
    always @* begin
        nxt_frame_base = frame_base_ff;
        nxt_pointer    = pointer_ff;
        if (IO_WR && sel_frame_base) begin
            nxt_frame_base = IO_WDATA;
        end
        if (IO_WR && sel_pointer) begin
            nxt_pointer = IO_WDATA[6:0];
        end else if (win_wr || win_rd) begin
            nxt_pointer[`EMP_PP_BYTE_BIT] = ~pointer_ff[`EMP_PP_BYTE_BIT];
        end
    end

    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            frame_base_ff <= `EMP_FB_RESET;
            pointer_ff    <= `EMP_PP_RESET;
            for (k = 0; k < 8; k = k + 1) begin
                upper_map_ff[k] <= `EMP_MR_RESET;
            end
        end else begin
            frame_base_ff <= nxt_frame_base;
            pointer_ff    <= nxt_pointer;
            if (IO_WR && sel_map) begin
                if (IO_ADDR[3:0] == `EMP_LO_MAP_LOW) begin
                    upper_map_ff[map_num][7:0] <= IO_WDATA;
                end else begin
                    upper_map_ff[map_num][15:8] <= IO_WDATA;
                end
            end
        end
    end

    // lower-window store; host side indexed by set and pointer index
    emp_map_ram #(
        .DEPTH_LOG2 (6),
        .WIDTH      (16)
    ) u_ram (
        .CLOCK      (CLOCK),
        .RESET_N    (RESET_N),
        .WR_EN      (win_wr),
        .WR_BYTE_EN ({pointer_ff[`EMP_PP_BYTE_BIT], ~pointer_ff[`EMP_PP_BYTE_BIT]}),
        .WR_ADDR    (pointer_ff[`EMP_PP_SET_BIT:`EMP_PP_INDEX_LSB]),
        .WR_DATA    ({IO_WDATA, IO_WDATA}),
        .RD_A_ADDR  (pointer_ff[`EMP_PP_SET_BIT:`EMP_PP_INDEX_LSB]),
        .RD_A_DATA  (ram_rd_a),
        .RD_B_ADDR  (ram_b_addr),
        .RD_B_DATA  (ram_rd_b)
    );

    // i/o reads: upper ports answer from a flop, window from the store register
    always @* begin
        nxt_io_rdata = 8'h00;
        if (IO_RD && sel_map) begin
            nxt_io_rdata = emp_byte_pick(upper_map_ff[map_num],
                                         IO_ADDR[3:0] == `EMP_LO_MAP_HIGH);
        end
    end

    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            io_rdata_ff    <= 8'h00;
            io_rvalid_ff   <= 1'b0;
            rd_from_ram_ff <= 1'b0;
            rd_byte_ff     <= 1'b0;
        end else begin
            io_rdata_ff    <= nxt_io_rdata;
            io_rvalid_ff   <= IO_RD && IO_HIT;
            rd_from_ram_ff <= win_rd;
            rd_byte_ff     <= pointer_ff[`EMP_PP_BYTE_BIT];
        end
    end

    assign IO_RDATA  = rd_from_ram_ff ? emp_byte_pick(ram_rd_a, rd_byte_ff) : io_rdata_ff;
    assign IO_RVALID = io_rvalid_ff;

    // memory translation, stage 1: window decode
    assign frame      = MEM_ADDR[19:14];
    assign below_1mb  = (MEM_ADDR[23:20] == 4'h0);
    assign in_low     = (frame >= `EMP_LOW_FIRST_FRAME) && (frame <= `EMP_LOW_LAST_FRAME);
    assign in_up      = (frame >= `EMP_UP_FIRST_FRAME) && (frame <= `EMP_UP_LAST_FRAME);
    assign low_off    = frame - `EMP_LOW_FIRST_FRAME;
    assign ram_b_addr = {pointer_ff[`EMP_PP_SET_BIT], low_off[4:0]};
    assign up_off     = up_off_f(frame);
    assign up_diff    = up_off - frame_base_ff[`EMP_FB_START_MSB:0];
    assign up_slot_ok = (up_off >= frame_base_ff[`EMP_FB_START_MSB:0])
                        && (up_diff < `EMP_UP_SLOTS);
    assign up_num     = {pointer_ff[`EMP_PP_SET_BIT], up_diff[1:0]};

    // frame offset from C0000h within the upper window
    function [3:0] up_off_f;
        input [5:0] f;
        reg   [5:0] d;
        begin
            d        = f - `EMP_UP_FIRST_FRAME;
            up_off_f = d[3:0];
        end
    endfunction

    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            s1_valid_ff   <= 1'b0;
            s1_low_ff     <= 1'b0;
            s1_up_ff      <= 1'b0;
            s1_up_word_ff <= `EMP_MR_RESET;
        end else begin
            s1_valid_ff   <= MEM_REQ;
            s1_low_ff     <= MEM_REQ && below_1mb && in_low
                             && LOW_FRAME_TAG[low_off[4:0]];
            s1_up_ff      <= MEM_REQ && below_1mb && in_up && up_slot_ok
                             && UPPER_FRAME_TAG[up_off];
            s1_up_word_ff <= upper_map_ff[up_num];
        end
    end

    // stage 2: enable check and page number
    assign s1_word    = s1_low_ff ? ram_rd_b : s1_up_word_ff;
    assign s1_enabled = (s1_low_ff || s1_up_ff) && s1_word[`EMP_MR_ENABLE_BIT];

    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            map_done_ff <= 1'b0;
            map_hit_ff  <= 1'b0;
            map_page_ff <= 11'h000;
            map_wait_ff <= 1'b0;
        end else begin
            map_done_ff <= s1_valid_ff;
            map_hit_ff  <= s1_valid_ff && s1_enabled;
            map_page_ff <= (s1_valid_ff && s1_enabled) ? emp_page(s1_word) : 11'h000;
            map_wait_ff <= s1_valid_ff && s1_enabled && s1_up_ff
                           && frame_base_ff[`EMP_FB_WAIT_BIT];
        end
    end

    assign MAP_DONE   = map_done_ff;
    assign MAP_HIT    = map_hit_ff;
    assign MAP_PAGE   = map_page_ff;
    assign MAP_WAIT   = map_wait_ff;
    assign PORTS_ON   = ports_en;
    assign ACTIVE_SET = pointer_ff[`EMP_PP_SET_BIT];

endmodule // emp_mapper

`default_nettype wire

// file: logic/emp_map.vh
// emp_map.vh: port offsets, field positions, reset values and window bounds
// for the expanded-memory page mapper.
// assumes inclusion by bare name from the logic/ folder.
`ifndef EMP_MAP_VH
`define EMP_MAP_VH

// i/o port layout: {high nibble, 4'h2, port nibble x, low nibble}
`define EMP_PORT_MID_NIB      4'h2
`define EMP_HI_FRAME_BASE     4'h0
`define EMP_HI_POINTER        4'h1
`define EMP_HI_WINDOW         4'h1
`define EMP_LO_FRAME_BASE     4'hA
`define EMP_LO_POINTER        4'hA
`define EMP_LO_WINDOW         4'hB
`define EMP_LO_MAP_LOW        4'h8
`define EMP_LO_MAP_HIGH       4'h9
// upper map ports: bit 13 clear, bit 12 = set, bits 15-14 = slot
`define EMP_MAP_SET_BIT       12
`define EMP_MAP_ZERO_BIT      13
`define EMP_MAP_SLOT_LSB      14

// frame base register fields
`define EMP_FB_PORT_EN_BIT    7
`define EMP_FB_WAIT_BIT       6
`define EMP_FB_START_MSB      3
`define EMP_FB_RESET          8'h00

// page pointer register fields
`define EMP_PP_SET_BIT        6
`define EMP_PP_INDEX_MSB      5
`define EMP_PP_INDEX_LSB      1
`define EMP_PP_BYTE_BIT       0
`define EMP_PP_RESET          7'h00

// mapping register fields
`define EMP_MR_ENABLE_BIT     7
`define EMP_MR_RESET          16'h0000

// 16 KB frame numbers (address bits 19-14) of the two windows
`define EMP_LOW_FIRST_FRAME   6'h10
`define EMP_LOW_LAST_FRAME    6'h2F
`define EMP_UP_FIRST_FRAME    6'h30
`define EMP_UP_LAST_FRAME     6'h3B
`define EMP_UP_SLOTS          4'h4

`endif

// file: logic/emp_map_ram.v
// emp_map_ram.v: mapping store for the lower window, one write port with
// byte enables and two read ports whose data come out of registers.
// assumes one clock; reads return the word stored before a same-edge write.
`default_nettype none

module emp_map_ram #(
    parameter DEPTH_LOG2 = 6,
    parameter WIDTH      = 16
) (
    input  wire                  CLOCK,
    input  wire                  RESET_N,
    input  wire                  WR_EN,
    input  wire [1:0]            WR_BYTE_EN,
    input  wire [DEPTH_LOG2-1:0] WR_ADDR,
    input  wire [WIDTH-1:0]      WR_DATA,
    input  wire [DEPTH_LOG2-1:0] RD_A_ADDR,
    output wire [WIDTH-1:0]      RD_A_DATA,
    input  wire [DEPTH_LOG2-1:0] RD_B_ADDR,
    output wire [WIDTH-1:0]      RD_B_DATA
);

    localparam DEPTH = 1 << DEPTH_LOG2;
    localparam HALF  = WIDTH / 2;

    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [WIDTH-1:0] rd_a_ff;
    reg [WIDTH-1:0] rd_b_ff;
    integer         i;

    // cleared at reset so every frame starts with mapping disabled
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_ff[i] <= {WIDTH{1'b0}};
            end
            rd_a_ff <= {WIDTH{1'b0}};
            rd_b_ff <= {WIDTH{1'b0}};
        end else begin
            if (WR_EN && WR_BYTE_EN[0]) begin
                mem_ff[WR_ADDR][HALF-1:0] <= WR_DATA[HALF-1:0];
            end
            if (WR_EN && WR_BYTE_EN[1]) begin
                mem_ff[WR_ADDR][WIDTH-1:HALF] <= WR_DATA[WIDTH-1:HALF];
            end
            rd_a_ff <= mem_ff[RD_A_ADDR];
            rd_b_ff <= mem_ff[RD_B_ADDR];
        end
    end

    assign RD_A_DATA = rd_a_ff;
    assign RD_B_DATA = rd_b_ff;

endmodule // emp_map_ram

`default_nettype wire

// file: verif/emp_mapper_assertions.sv
// emp_mapper_assertions.sv: port-level checks of the page mapper.
// assumes binding onto emp_mapper; one clock, synchronous active-low reset.
`default_nettype none

module emp_mapper_assertions #(
    parameter logic [3:0] PORT_X = 4'h8
) (
    input wire logic        CLOCK,
    input wire logic        RESET_N,
    input wire logic [15:0] IO_ADDR,
    input wire logic        IO_WR,
    input wire logic        IO_RD,
    input wire logic [7:0]  IO_WDATA,
    input wire logic        IO_HIT,
    input wire logic        IO_RVALID,
    input wire logic        MEM_REQ,
    input wire logic [23:0] MEM_ADDR,
    input wire logic        MAP_DONE,
    input wire logic        MAP_HIT,
    input wire logic [10:0] MAP_PAGE,
    input wire logic        MAP_WAIT,
    input wire logic        PORTS_ON,
    input wire logic        ACTIVE_SET
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] FB_PORT = {8'h02, PORT_X, 4'hA};
    localparam logic [15:0] PP_PORT = {8'h12, PORT_X, 4'hA};
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);

    property p_read_answer; IO_RD && IO_HIT |=> IO_RVALID; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_no_answer; !(IO_RD && IO_HIT) |=> !IO_RVALID; endproperty
    a_no_answer: assert property (p_no_answer) else $error("stray read answer");
    property p_ports_off; !PORTS_ON && IO_ADDR != FB_PORT |-> !IO_HIT; endproperty
    a_ports_off: assert property (p_ports_off) else $error("port hit while off");
    property p_base_on; IO_WR && IO_ADDR == FB_PORT |=> PORTS_ON == $past(IO_WDATA[7]); endproperty
    a_base_on: assert property (p_base_on) else $error("port enable not loaded");
    property p_set_sel; IO_WR && IO_HIT && IO_ADDR == PP_PORT |=> ACTIVE_SET == $past(IO_WDATA[6]);
    endproperty
    a_set_sel: assert property (p_set_sel) else $error("set select not loaded");
    property p_done_lat; MAP_DONE == $past(MEM_REQ, 2); endproperty
    a_done_lat: assert property (p_done_lat) else $error("map result late");
    property p_above_1mb; MEM_REQ && MEM_ADDR[23:20] != 4'h0 |-> ##2 !MAP_HIT; endproperty
    a_above_1mb: assert property (p_above_1mb) else $error("hit above 1 MB");
    property p_lower_no_wait; MEM_REQ && MEM_ADDR[19:18] != 2'b11 |-> ##2 !MAP_WAIT; endproperty
    a_lower_no_wait: assert property (p_lower_no_wait) else $error("wait outside upper");
    property p_pass_zero; MAP_DONE && !MAP_HIT |-> MAP_PAGE == 11'h000 && !MAP_WAIT; endproperty
    a_pass_zero: assert property (p_pass_zero) else $error("untranslated with page");
    property p_pn_bit7; MAP_DONE |-> !MAP_PAGE[7]; endproperty
    a_pn_bit7: assert property (p_pn_bit7) else $error("page bit 7 set");
endmodule // emp_mapper_assertions

`default_nettype wire

// file: verif/emp_host.sv
// emp_host.sv: host processor model issuing i/o port cycles and memory requests.
// assumes the mapper samples its inputs on the rising CLOCK edge.
`default_nettype none

module emp_host (
    input  wire logic        CLOCK,
    output var  logic [15:0] IO_ADDR,
    output var  logic        IO_WR,
    output var  logic        IO_RD,
    output var  logic [7:0]  IO_WDATA,
    output var  logic        MEM_REQ,
    output var  logic [23:0] MEM_ADDR,
    input  wire logic        IO_RVALID,
    input  wire logic [7:0]  IO_RDATA,
    input  wire logic [13:0] MAP_RES
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {IO_ADDR, IO_WR, IO_RD, IO_WDATA, MEM_REQ, MEM_ADDR} = '0;

    // released bus lines show the inverse of the last value
    task automatic io(input logic [15:0] a, input logic [7:0] d, input logic wr);
        @(posedge CLOCK);
        #1;
        IO_ADDR = a;
        IO_WDATA = d;
        IO_WR = wr;
        IO_RD = !wr;
        @(posedge CLOCK);
        #1;
        {IO_WR, IO_RD} = 2'b00;
        IO_ADDR = ~a;
        IO_WDATA = ~d;
    endtask

    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        io(a, d, 1'b1);
    endtask

    task automatic io_rd(input logic [15:0] a, output logic [8:0] r);
        io(a, 8'h00, 1'b0);
        r = {IO_RVALID, IO_RVALID ? IO_RDATA : 8'h00};
    endtask

    task automatic mem(input logic [23:0] a, output logic [13:0] r);
        @(posedge CLOCK);
        #1;
        MEM_ADDR = a;
        MEM_REQ = 1'b1;
        @(posedge CLOCK);
        #1;
        MEM_REQ = 1'b0;
        MEM_ADDR = ~a;
        @(posedge CLOCK);
        #1;
        r = MAP_RES;
    endtask
endmodule // emp_host

`default_nettype wire

// file: verif/tb_top.sv
// tb_top.sv: directed tests of the page mapper driven through the host model.
// assumes emp_mapper with PORT_X = 8 and the checker bound at the foot.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] FB = 16'h028A;
    localparam logic [15:0] PP = 16'h128A;
    localparam logic [15:0] WIN = 16'h128B;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic [31:0] low_tag = 32'h0;
    logic [11:0] up_tag = 12'h0;
    int          n_fail = 0;
    int          samples_checked = 0;
    wire  [15:0] io_addr;
    wire  [7:0]  io_wdata;
    wire  [7:0]  io_rdata;
    wire  [23:0] mem_addr;
    wire  [10:0] map_page;
    wire         io_wr, io_rd, io_rvalid, mem_req, map_done, map_hit, map_wait;
    wire         ports_on, active_set;

    always #25 clock = ~clock;

    emp_mapper #(.PORT_X(4'h8)) u_emp_mapper (
        .CLOCK(clock), .RESET_N(reset_n), .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd),
        .IO_WDATA(io_wdata), .IO_HIT(), .IO_RDATA(io_rdata), .IO_RVALID(io_rvalid),
        .MEM_REQ(mem_req), .MEM_ADDR(mem_addr), .LOW_FRAME_TAG(low_tag),
        .UPPER_FRAME_TAG(up_tag), .MAP_DONE(map_done), .MAP_HIT(map_hit),
        .MAP_PAGE(map_page), .MAP_WAIT(map_wait), .PORTS_ON(ports_on), .ACTIVE_SET(active_set)
    );
    emp_host u_emp_host (
        .CLOCK(clock), .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd), .IO_WDATA(io_wdata),
        .MEM_REQ(mem_req), .MEM_ADDR(mem_addr), .IO_RVALID(io_rvalid), .IO_RDATA(io_rdata),
        .MAP_RES({map_done, map_hit, map_wait, map_page})
    );

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd(input logic [15:0] a, input logic [8:0] exp);
        logic [8:0] r;
        u_emp_host.io_rd(a, r);
        chk("io_read", {7'h00, exp}, {7'h00, r});
    endtask

    task automatic mp(input logic [23:0] a, input logic h, input logic w, input logic [10:0] p);
        logic [13:0] r;
        u_emp_host.mem(a, r);
        chk("map_result", {3'b001, h, w, p}, {2'b00, r});
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] lo, input logic [7:0] hi);
        u_emp_host.io_wr(a, lo);
        u_emp_host.io_wr(a | 16'h0001, hi);
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clock);
        #1 reset_n = 1'b1;
        u_emp_host.io_wr(PP, 8'h02);
        rd(WIN, 9'h000);
        chk("ports_set", 16'h0000, {14'h0, ports_on, active_set});
        $display("test reset done");
        u_emp_host.io_wr(FB, 8'h81);
        u_emp_host.io_wr(PP, 8'h02);
        wr(WIN, 8'h85, 8'h03);
        u_emp_host.io_wr(PP, 8'h02);
        rd(WIN, 9'h185);
        rd(WIN, 9'h103);
        rd(WIN, 9'h185);
        rd(16'h128C, 9'h000);
        u_emp_host.io_wr(PP, 8'h3E);
        wr(WIN, 8'hFF, 8'h07);
        $display("test window done");
        low_tag = 32'h8000_0003;
        mp(24'h044000, 1'b1, 1'b0, 11'h305);
        mp(24'h0BFFFF, 1'b1, 1'b0, 11'h77F);
        mp(24'h040000, 1'b0, 1'b0, 11'h000);
        mp(24'h144000, 1'b0, 1'b0, 11'h000);
        low_tag = 32'h0;
        mp(24'h044000, 1'b0, 1'b0, 11'h000);
        low_tag = 32'h2;
        $display("test lower done");
        u_emp_host.io_wr(PP, 8'hC2);
        chk("set", 16'h0001, {15'h0, active_set});
        wr(WIN, 8'h11, 8'h02);
        mp(24'h044000, 1'b0, 1'b0, 11'h000);
        wr(WIN, 8'h91, 8'h02);
        mp(24'h044000, 1'b1, 1'b0, 11'h211);
        u_emp_host.io_wr(PP, 8'h02);
        mp(24'h044000, 1'b1, 1'b0, 11'h305);
        $display("test sets done");
        up_tag = 12'h107;
        wr(16'h0288, 8'h8A, 8'hF9);
        wr(16'h4288, 8'h83, 8'h00);
        mp(24'h0C4000, 1'b1, 1'b0, 11'h10A);
        mp(24'h0CBFFF, 1'b1, 1'b0, 11'h003);
        mp(24'h0C0000, 1'b0, 1'b0, 11'h000);
        u_emp_host.io_wr(FB, 8'hF1);
        mp(24'h0C4000, 1'b1, 1'b1, 11'h10A);
        mp(24'h044000, 1'b1, 1'b0, 11'h305);
        wr(16'h1288, 8'h84, 8'h00);
        u_emp_host.io_wr(PP, 8'h40);
        u_emp_host.io_wr(FB, 8'h88);
        mp(24'h0E0000, 1'b1, 1'b0, 11'h004);
        $display("test upper done");
        u_emp_host.io_wr(FB, 8'h00);
        rd(WIN, 9'h000);
        u_emp_host.io_wr(16'h1288, 8'h00);
        u_emp_host.io_wr(FB, 8'h80);
        mp(24'h0C0000, 1'b1, 1'b0, 11'h004);
        $display("test disable done");
        end_sim();
    end

    initial begin
        repeat (5000) @(posedge clock);
        n_fail++;
        end_sim();
    end
endmodule // tb_top

bind emp_mapper emp_mapper_assertions #(.PORT_X(PORT_X)) u_emp_mapper_assertions (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD),
    .IO_WDATA(IO_WDATA), .IO_HIT(IO_HIT), .IO_RVALID(IO_RVALID), .MEM_REQ(MEM_REQ),
    .MEM_ADDR(MEM_ADDR), .MAP_DONE(MAP_DONE), .MAP_HIT(MAP_HIT), .MAP_PAGE(MAP_PAGE),
    .MAP_WAIT(MAP_WAIT), .PORTS_ON(PORTS_ON), .ACTIVE_SET(ACTIVE_SET)
);

`default_nettype wire
